// ===== shared/ttc_defs.svh
/*
 * Constants of the trigger timestamp counter: register indices, command
 * and edge codes, bus responses, field widths and timing.
 * Assumes inclusion by the package, the design files and the bench.
 */
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH

// register indices; byte address is four times the index
`define TTC_IDX_CMD 30'h0000B798
`define TTC_IDX_START 30'h0000B7B6
`define TTC_IDX_EDGE 30'h0000B7CA
`define TTC_IDX_STAT 30'h0000B7D4
`define TTC_IDX_CNT_LO 30'h0000B7D8
`define TTC_IDX_CNT_HI 30'h0000B7D9

// command and readback codes
`define TTC_CMD_CLEAR 32'h00000000
`define TTC_CMD_OFF 32'h0000000A
`define TTC_CMD_RUN 32'h0000000B
`define TTC_CMD_FREE 32'h0000000C
`define TTC_CMD_SPLIT 32'h0000000D

// pulse edge codes
`define TTC_EDGE_RISE 32'h0000000A
`define TTC_EDGE_FALL 32'h00000014

// status fields
`define TTC_STAT_WAIT_BIT 0
`define TTC_STAT_LOST_BIT 1

// bus answers
`define TTC_RESP_OKAY 2'h0
`define TTC_RESP_SLVERR 2'h2
`define TTC_STRB_ALL 4'hF

// widths: low part counts samples, high part counts seconds in split mode and carries of the low part otherwise
`define TTC_LO_W 32
`define TTC_HI_W 24
`define TTC_WAIT_W 28

// reset values
`define TTC_RST_START 32'h00000000

// timing: longest wait for the seconds pulse after a clear
`define TTC_SYNC_WAIT_S 1
`define TTC_CLK_MHZ 250

`endif

// ===== shared/ttc_pkg.sv
/*
 * Types of the trigger timestamp counter: mode enum, bus carriers and
 * the state records of both modules.
 * Assumes ttc_defs.svh is reachable on the include path.
 */
`include "ttc_defs.svh"

package ttc_pkg;

	typedef enum logic [1:0] {
		TTC_MODE_OFF = 2'b00,
		TTC_MODE_FREE = 2'b01,
		TTC_MODE_RUN = 2'b10,
		TTC_MODE_SPLIT = 2'b11
	} ttc_mode_e;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} ttc_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ttc_axi_rsp_s;

	typedef struct packed {
		logic valid;
		logic [`TTC_HI_W+`TTC_LO_W-1:0] stamp;
	} ttc_stamp_s;

	typedef struct packed {
		logic prev;
	} ttc_edge_s;

	typedef struct packed {
		ttc_mode_e mode;
		logic [`TTC_HI_W-1:0] cnt_hi;
		logic [`TTC_LO_W-1:0] cnt_lo;
		logic sync_wait;
		logic sync_lost;
		logic [`TTC_WAIT_W-1:0] wait_cnt;
		logic edge_fall;
		logic [31:0] start_time;
		logic aw_have;
		logic [31:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		ttc_axi_rsp_s rsp;
		ttc_stamp_s ts;
	} ttc_state_s;

endpackage : ttc_pkg

// ===== hdl/ttc_edge_det.sv
/*
 * Edge detector: flags rising and falling edges of a level input.
 * Assumes the level is synchronous to core_clk_i.
 */
`timescale 1ns/10ps

module ttc_edge_det (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// level in, edges out
	input wire logic level_i,
	output logic rise_o,
	output logic fall_o
);
	import ttc_pkg::*;

	ttc_edge_s q, d;

	always_comb begin
		d = q;
		d.prev = level_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// same-cycle flags keep capture latency to one edge
	assign rise_o = level_i && !q.prev;
	assign fall_o = !level_i && q.prev;

endmodule : ttc_edge_det

// ===== hdl/ttc_core.sv
/*
 * Trigger timestamp counter with AXI4-Lite registers: wide counter with
 * three modes, seconds-pulse sync, capture of trigger and gate edges.
 * Assumes synchronous inputs at 250 MHz; the stamp buffer sits outside.
 */
// Added by the designer: the AXI4-Lite register port.
// Notes on behaviour
// - free-running: counter zeroes only on software clear, then counts on
// - command value 0 clears the counter to zero
// - command value 10 disables the unit; no further captures
// - command value 12 selects free-running mode
// - command value 11 selects run mode; counter zeroes at each start
// - command register reads back the current mode code
// - split mode: counter has seconds part and sample part
// - seconds part counts pulses since the last clear
// - sample part counts clocks, zeroes on each selected pulse edge
// - command value 13 selects split mode; still needs a clear
// - split clear zeroes all, then waits up to one second for pulse
// - edge register: 10 picks rising, 20 picks falling pulse edge
// - clear behaviour does not depend on the selected edge
// - start time register gives epoch seconds of the split reference
// - counter steps once per sample clock while active
// - each trigger stores the present counter value as a stamp
// - gated acquisition stamps both start and end of each segment
// - stamps go to a first-in first-out buffer of 64K entries
`timescale 1ns/10ps
`include "ttc_defs.svh"

module ttc_core #(
	parameter int unsigned SYNC_WAIT_CYC =
		`TTC_SYNC_WAIT_S * `TTC_CLK_MHZ * 1000000
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// register bus
	input wire ttc_pkg::ttc_axi_req_s axi_req_i,
	output ttc_pkg::ttc_axi_rsp_s axi_rsp_o,
	// acquisition events
	input wire logic acq_start_i,
	input wire logic trig_i,
	input wire logic gated_mode_i,
	input wire logic gate_i,
	// seconds pulse and wall time
	input wire logic sec_pulse_i,
	input wire logic [31:0] epoch_sec_i,
	// captured stamps
	output ttc_pkg::ttc_stamp_s stamp_o
);
	import ttc_pkg::*;

	ttc_state_s q, d;
	logic sec_rise, sec_fall, gate_rise, gate_fall;
	logic do_wr, wr_cmd, wr_edge, sel_edge, counting, cap_evt, sync_to;
	logic [31:0] wr_val;
	logic [29:0] wr_idx, rd_idx;
	logic [1:0] lvl_v, rise_v, fall_v;

	// index 0 is the seconds pulse, index 1 the gate
	assign lvl_v = {gate_i, sec_pulse_i};
	for (genvar g = 0; g < 2; g++) begin : g_edge
		ttc_edge_det u_edge (
			.core_clk_i(core_clk_i),
			.rst_b_i(rst_b_i),
			.level_i(lvl_v[g]),
			.rise_o(rise_v[g]),
			.fall_o(fall_v[g])
		);
	end
	assign sec_rise = rise_v[0];
	assign sec_fall = fall_v[0];
	assign gate_rise = rise_v[1];
	assign gate_fall = fall_v[1];

	function automatic logic idx_mapped(input logic [29:0] idx);
		idx_mapped = (idx == `TTC_IDX_CMD) || (idx == `TTC_IDX_START) ||
			(idx == `TTC_IDX_EDGE) || (idx == `TTC_IDX_STAT) ||
			(idx == `TTC_IDX_CNT_LO) || (idx == `TTC_IDX_CNT_HI);
	endfunction : idx_mapped

	function automatic logic [31:0] mode_code(input ttc_mode_e m);
		case (m)
			TTC_MODE_FREE: mode_code = `TTC_CMD_FREE;
			TTC_MODE_RUN: mode_code = `TTC_CMD_RUN;
			TTC_MODE_SPLIT: mode_code = `TTC_CMD_SPLIT;
			default: mode_code = `TTC_CMD_OFF;
		endcase
	endfunction : mode_code

	assign wr_idx = q.aw_addr[31:2];
	assign rd_idx = axi_req_i.araddr[31:2];
	assign wr_val = q.w_data;
	// partial writes are answered but not applied: codes need a whole word
	assign do_wr = q.aw_have && q.w_have && !q.rsp.bvalid;
	assign wr_cmd = do_wr && (wr_idx == `TTC_IDX_CMD) &&
		(q.w_strb == `TTC_STRB_ALL);
	assign wr_edge = do_wr && (wr_idx == `TTC_IDX_EDGE) &&
		(q.w_strb == `TTC_STRB_ALL);
	assign sel_edge = q.edge_fall ? sec_fall : sec_rise;
	assign counting = (q.mode != TTC_MODE_OFF) && !q.sync_wait;
	assign cap_evt = gated_mode_i ? (gate_rise || gate_fall) : trig_i;
	// last cycle of the wait for the first pulse
	assign sync_to = q.sync_wait && !sec_rise &&
		(q.wait_cnt == `TTC_WAIT_W'(SYNC_WAIT_CYC - 1));

	always_comb begin
		d = q;
		// write address and data, taken in either order
		if (axi_req_i.awvalid && q.rsp.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid && q.rsp.wready) begin
			d.w_have = 1'b1;
			d.w_data = axi_req_i.wdata;
			d.w_strb = axi_req_i.wstrb;
		end
		if (q.rsp.bvalid && axi_req_i.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (do_wr) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = idx_mapped(wr_idx) ? `TTC_RESP_OKAY :
				`TTC_RESP_SLVERR;
		end
		d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
		d.rsp.wready = !d.w_have && !d.rsp.bvalid;
		// read channel: one read at a time
		if (q.rsp.rvalid && axi_req_i.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (axi_req_i.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = idx_mapped(rd_idx) ? `TTC_RESP_OKAY :
				`TTC_RESP_SLVERR;
			case (rd_idx)
				`TTC_IDX_CMD: d.rsp.rdata = mode_code(q.mode);
				`TTC_IDX_START: d.rsp.rdata = q.start_time;
				`TTC_IDX_EDGE: d.rsp.rdata = q.edge_fall ?
					`TTC_EDGE_FALL : `TTC_EDGE_RISE;
				`TTC_IDX_STAT: begin
					d.rsp.rdata = '0;
					d.rsp.rdata[`TTC_STAT_WAIT_BIT] = q.sync_wait;
					d.rsp.rdata[`TTC_STAT_LOST_BIT] = q.sync_lost;
				end
				`TTC_IDX_CNT_LO: d.rsp.rdata = q.cnt_lo;
				`TTC_IDX_CNT_HI: d.rsp.rdata = {8'h00, q.cnt_hi};
				default: d.rsp.rdata = '0;
			endcase
		end
		d.rsp.arready = !d.rsp.rvalid;

		// counter stepping; a disabled unit holds its value
		if (counting) begin
			if (q.mode == TTC_MODE_SPLIT) begin
				if (sel_edge) begin
					d.cnt_lo = '0;
					d.cnt_hi = q.cnt_hi + 1'b1;
				end else begin
					d.cnt_lo = q.cnt_lo + 1'b1;
				end
			end else begin
				{d.cnt_hi, d.cnt_lo} = {q.cnt_hi, q.cnt_lo} + 1'b1;
				if (q.mode == TTC_MODE_RUN && acq_start_i) begin
					d.cnt_hi = '0;
					d.cnt_lo = '0;
				end
			end
		end

		// sync wait after a split clear; always the rising edge
		if (q.sync_wait) begin
			if (sec_rise) begin
				d.sync_wait = 1'b0;
				d.start_time = epoch_sec_i;
			end else if (sync_to) begin
				// no pulse in time: run free, flag it for software
				d.sync_wait = 1'b0;
				d.sync_lost = 1'b1;
			end else begin
				d.wait_cnt = q.wait_cnt + 1'b1;
			end
		end

		if (wr_edge) begin
			case (wr_val)
				`TTC_EDGE_RISE: d.edge_fall = 1'b0;
				`TTC_EDGE_FALL: d.edge_fall = 1'b1;
				default: d.edge_fall = q.edge_fall;
			endcase
		end

		// commands override the stepping above
		if (wr_cmd) begin
			case (wr_val)
				`TTC_CMD_CLEAR: begin
					d.cnt_hi = '0;
					d.cnt_lo = '0;
					d.sync_lost = sync_to; // a timeout this cycle still flags
					d.wait_cnt = '0;
					d.sync_wait = (q.mode == TTC_MODE_SPLIT);
				end
				`TTC_CMD_OFF: begin
					d.mode = TTC_MODE_OFF;
					d.sync_wait = 1'b0;
				end
				`TTC_CMD_RUN: d.mode = TTC_MODE_RUN;
				`TTC_CMD_FREE: d.mode = TTC_MODE_FREE;
				`TTC_CMD_SPLIT: d.mode = TTC_MODE_SPLIT;
				default: d.mode = q.mode;
			endcase
		end

		// stamp of the value present at the event; buffer is downstream
		d.ts.valid = (q.mode != TTC_MODE_OFF) && cap_evt;
		d.ts.stamp = {q.cnt_hi, q.cnt_lo};
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			q <= '0;
			q.start_time <= `TTC_RST_START;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp_o = q.rsp;
	assign stamp_o = q.ts;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_split_clear;
		wr_cmd && (wr_val == `TTC_CMD_CLEAR) && q.mode == TTC_MODE_SPLIT;
	endsequence

	sequence s_synced;
		q.sync_wait ##1 !q.sync_wait && !q.sync_lost && q.mode != TTC_MODE_OFF;
	endsequence

	property p_clear_zero;
		wr_cmd && (wr_val == `TTC_CMD_CLEAR) |=>
			q.cnt_lo == '0 && q.cnt_hi == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("clear command did not zero the counter");

	property p_off;
		wr_cmd && (wr_val == `TTC_CMD_OFF) |=> q.mode == TTC_MODE_OFF
			##1 !q.ts.valid;
	endproperty
	a_off: assert property (p_off)
		else $error("disable command not obeyed");

	property p_modes;
		wr_cmd && (wr_val == `TTC_CMD_FREE) |=> q.mode == TTC_MODE_FREE;
	endproperty
	a_modes: assert property (p_modes)
		else $error("free mode not selected");

	property p_run_start;
		q.mode == TTC_MODE_RUN && !q.sync_wait && acq_start_i && !wr_cmd
			|=> q.cnt_lo == '0 ##1 q.cnt_lo == 1;
	endproperty
	a_run_start: assert property (p_run_start)
		else $error("run start did not restart the counter");

	property p_mode_read;
		axi_req_i.arvalid && axi_rsp_o.arready && rd_idx == `TTC_IDX_CMD
			|=> axi_rsp_o.rvalid && axi_rsp_o.rdata == mode_code($past(q.mode));
	endproperty
	a_mode_read: assert property (p_mode_read)
		else $error("command read does not give the mode");

	property p_split_edge;
		q.mode == TTC_MODE_SPLIT && counting && sel_edge && !wr_cmd |=>
			q.cnt_lo == '0 && q.cnt_hi == $past(q.cnt_hi) + 1'b1;
	endproperty
	a_split_edge: assert property (p_split_edge)
		else $error("seconds edge handling wrong");

	property p_split_sync;
		s_split_clear |=> q.sync_wait && q.cnt_lo == '0 ##1 q.cnt_lo == '0;
	endproperty
	a_split_sync: assert property (p_split_sync)
		else $error("split clear did not wait for the pulse");

	property p_sync_start;
		s_synced |-> q.cnt_lo == '0 && q.start_time == $past(epoch_sec_i, 1);
	endproperty
	a_sync_start: assert property (p_sync_start)
		else $error("start time not taken at sync");

	property p_hold_off;
		q.mode == TTC_MODE_OFF && !wr_cmd |=>
			$stable(q.cnt_lo) && $stable(q.cnt_hi) && !q.ts.valid;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("disabled unit changed or captured");

	property p_bad_cmd;
		wr_cmd && !(wr_val inside {`TTC_CMD_CLEAR, `TTC_CMD_OFF,
			`TTC_CMD_RUN, `TTC_CMD_FREE, `TTC_CMD_SPLIT}) |=> $stable(q.mode);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd)
		else $error("undefined command changed the mode");

	property p_step;
		q.mode == TTC_MODE_FREE && !q.sync_wait && !wr_cmd |=>
			q.cnt_lo == $past(q.cnt_lo) + 1'b1;
	endproperty
	a_step: assert property (p_step)
		else $error("counter did not step once");

	property p_capture;
		q.mode != TTC_MODE_OFF && trig_i && !gated_mode_i |=>
			stamp_o.valid && stamp_o.stamp == $past({q.cnt_hi, q.cnt_lo});
	endproperty
	a_capture: assert property (p_capture)
		else $error("trigger stamp missing or wrong");

	property p_gate;
		q.mode != TTC_MODE_OFF && gated_mode_i && (gate_rise || gate_fall)
			|=> stamp_o.valid;
	endproperty
	a_gate: assert property (p_gate)
		else $error("gate edge not stamped");

	property p_rise_ignored;
		q.mode == TTC_MODE_SPLIT && counting && q.edge_fall && sec_rise &&
			!wr_cmd |=> q.cnt_lo == $past(q.cnt_lo) + 1'b1;
	endproperty
	a_rise_ignored: assert property (p_rise_ignored)
		else $error("unselected pulse edge cleared the count");

	property p_sync_lost;
		sync_to && !wr_cmd |=> !q.sync_wait && q.sync_lost;
	endproperty
	a_sync_lost: assert property (p_sync_lost)
		else $error("missing pulse did not end the wait");

	property p_split_mode;
		wr_cmd && (wr_val == `TTC_CMD_SPLIT) |=> q.mode == TTC_MODE_SPLIT;
	endproperty
	a_split_mode: assert property (p_split_mode)
		else $error("split mode not selected");

endmodule : ttc_core

// ===== verification/ttc_sec_src.sv
/*
 * Seconds pulse source beside the timestamp counter.
 * Assumes one clock; PERIOD is shortened from one second for sim.
 */
`timescale 1ns/10ps

module ttc_sec_src #(
	parameter int PERIOD = 100
) (
	// clock and enable
	input wire logic core_clk_i,
	input wire logic en_i,
	// pulse out
	output logic sec_pulse_o
);
	int cnt_q;

	// line idles low when the source is off, as a ttl output would
	always_ff @(posedge core_clk_i) begin
		if (!en_i) begin
			cnt_q <= 0;
			sec_pulse_o <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
			sec_pulse_o <= (cnt_q >= PERIOD / 2);
		end
	end
endmodule : ttc_sec_src

// ===== verification/ttc_core_tb.sv
/*
 * Self-checking bench of the timestamp counter: register table, modes,
 * stamps and seconds sync. Assumes ttc_pkg and ttc_defs.svh compiled.
 */
`timescale 1ns/10ps
`include "ttc_defs.svh"

module ttc_core_tb;
	import ttc_pkg::*;
	typedef struct packed {
		logic we;
		logic [29:0] idx;
		logic [31:0] wd;
		logic [31:0] ex;
	} ttc_row_s;
	logic clk = 0, rst_b = 0, acq = 0, trig = 0, gated = 0, gate = 0;
	logic sec_en = 0, sec;
	logic [31:0] epoch = 32'h5F5E1000, d;
	logic [1:0] r;
	logic [55:0] s1, s2;
	logic v;
	ttc_axi_req_s req = '0;
	ttc_axi_rsp_s rsp;
	ttc_stamp_s stamp;
	int num_errors = 0, cmp_count = 0;
	ttc_row_s rows [10];

	always #2 clk = ~clk;

	ttc_core #(.SYNC_WAIT_CYC(400)) i_ttc_core (.core_clk_i(clk),
		.rst_b_i(rst_b), .axi_req_i(req), .axi_rsp_o(rsp),
		.acq_start_i(acq), .trig_i(trig), .gated_mode_i(gated),
		.gate_i(gate), .sec_pulse_i(sec), .epoch_sec_i(epoch),
		.stamp_o(stamp));
	ttc_sec_src #(.PERIOD(100)) i_ttc_sec_src (.core_clk_i(clk),
		.en_i(sec_en), .sec_pulse_o(sec));

	task automatic chk(input logic [63:0] seen, input logic [63:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, ex);
		end
	endtask : chk

	task automatic wr(input logic [29:0] idx, input logic [31:0] wd);
		logic a, w;
		a = 0;
		w = 0;
		@(posedge clk);
		req.awvalid <= 1;
		req.awaddr <= {idx, 2'b00};
		req.wvalid <= 1;
		req.wdata <= wd;
		req.wstrb <= `TTC_STRB_ALL;
		req.bready <= 1;
		while (!(a && w)) begin
			@(posedge clk);
			if (!a && rsp.awready) begin
				a = 1;
				req.awvalid <= 0;
			end
			if (!w && rsp.wready) begin
				w = 1;
				req.wvalid <= 0;
			end
		end
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		chk(rsp.bresp, `TTC_RESP_OKAY);
		req.bready <= 0;
	endtask : wr

	task automatic rd(input logic [29:0] idx, output logic [31:0] dt,
		output logic [1:0] rs);
		@(posedge clk);
		req.arvalid <= 1;
		req.araddr <= {idx, 2'b00};
		req.rready <= 1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 0;
		while (rsp.rvalid !== 1'b1) @(posedge clk);
		dt = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 0;
	endtask : rd

	// one event: trigger pulse, or a gate toggle when g is set
	task automatic ev(input bit g, output logic [55:0] s, output logic vl);
		@(posedge clk);
		if (g) gate <= ~gate;
		else trig <= 1;
		@(posedge clk);
		trig <= 0;
		#1;
		vl = stamp.valid;
		s = stamp.stamp;
	endtask : ev

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	initial begin
		#200000;
		num_errors++;
		results();
	end

	initial begin
		rows = '{
			'{1'b0, `TTC_IDX_CMD, 32'h0, `TTC_CMD_OFF},
			'{1'b0, `TTC_IDX_EDGE, 32'h0, `TTC_EDGE_RISE},
			'{1'b0, `TTC_IDX_START, 32'h0, `TTC_RST_START},
			'{1'b1, `TTC_IDX_CMD, `TTC_CMD_RUN, `TTC_CMD_RUN},
			'{1'b1, `TTC_IDX_CMD, `TTC_CMD_FREE, `TTC_CMD_FREE},
			'{1'b1, `TTC_IDX_CMD, `TTC_CMD_SPLIT, `TTC_CMD_SPLIT},
			'{1'b1, `TTC_IDX_CMD, `TTC_CMD_OFF, `TTC_CMD_OFF},
			'{1'b1, `TTC_IDX_CMD, 32'h7, `TTC_CMD_OFF},
			'{1'b1, `TTC_IDX_EDGE, `TTC_EDGE_FALL, `TTC_EDGE_FALL},
			'{1'b1, `TTC_IDX_EDGE, 32'h5, `TTC_EDGE_FALL}};
		repeat (16) @(posedge clk);
		rst_b <= 1;
		foreach (rows[i]) begin
			if (rows[i].we) wr(rows[i].idx, rows[i].wd);
			rd(rows[i].idx, d, r);
			chk(d, rows[i].ex);
		end
		rd(30'h100, d, r);
		chk(r, `TTC_RESP_SLVERR);
		$display("test registers done");
		// disabled: no stamp
		ev(0, s1, v);
		chk(v, 0);
		wr(`TTC_IDX_CMD, `TTC_CMD_FREE);
		wr(`TTC_IDX_CMD, `TTC_CMD_CLEAR);
		ev(0, s1, v);
		chk(v, 1);
		chk(s1 < 8, 1);
		ev(0, s2, v);
		chk(s2 - s1, 2);
		@(posedge clk);
		gated <= 1;
		ev(1, s1, v);
		chk(v, 1);
		ev(1, s1, v);
		chk(v, 1);
		@(posedge clk);
		gated <= 0;
		$display("test free done");
		wr(`TTC_IDX_CMD, `TTC_CMD_RUN);
		@(posedge clk);
		acq <= 1;
		@(posedge clk);
		acq <= 0;
		@(posedge clk);
		ev(0, s1, v);
		chk(s1, 2);
		$display("test run done");
		// split: falling edge picked, sync still waits on a rise
		wr(`TTC_IDX_CMD, `TTC_CMD_SPLIT);
		wr(`TTC_IDX_CMD, `TTC_CMD_CLEAR);
		ev(0, s1, v);
		chk(s1, 0);
		rd(`TTC_IDX_STAT, d, r);
		chk(d, 32'h00000001 << `TTC_STAT_WAIT_BIT);
		sec_en <= 1;
		@(posedge sec);
		repeat (4) @(posedge clk);
		ev(0, s1, v);
		chk(s1[55:32], 0);
		@(negedge sec);
		repeat (2) @(posedge clk);
		ev(0, s1, v);
		chk(s1[55:32], 1);
		chk(s1[31:0] < 8, 1);
		@(negedge sec);
		@(posedge clk);
		ev(0, s2, v);
		chk(s2[55:32], 2);
		rd(`TTC_IDX_START, d, r);
		chk(d, epoch);
		rd(`TTC_IDX_CNT_HI, d, r);
		chk(d, 32'h00000002);
		$display("test split done");
		// mid-run reset, then a clear with no pulse must time out
		sec_en <= 0;
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		rd(`TTC_IDX_CMD, d, r);
		chk(d, `TTC_CMD_OFF);
		rd(`TTC_IDX_EDGE, d, r);
		chk(d, `TTC_EDGE_RISE);
		rd(`TTC_IDX_START, d, r);
		chk(d, `TTC_RST_START);
		$display("test reset done");
		wr(`TTC_IDX_CMD, `TTC_CMD_SPLIT);
		wr(`TTC_IDX_CMD, `TTC_CMD_CLEAR);
		repeat (420) @(posedge clk);
		rd(`TTC_IDX_STAT, d, r);
		chk(d, 32'h00000001 << `TTC_STAT_LOST_BIT);
		$display("test timeout done");
		results();
	end
endmodule : ttc_core_tb
